/* design/mirror_link_map.vh */
// Bit positions, widths and timing figures of the mirror link parallel port
`ifndef MIRROR_LINK_MAP_VH
`define MIRROR_LINK_MAP_VH
`define CLK_FREQ_HZ 10000000
`define DL_PERIOD_US 100
`define DL_PERIOD_CYC ((`DL_PERIOD_US * `CLK_FREQ_HZ) / 1000000)
`define UV_GAP_US 15
`define UV_GAP_CYC ((`UV_GAP_US * `CLK_FREQ_HZ) / 1000000)
`define DL_RECOVER_MS 10
`define DL_RECOVER_CYC ((`DL_RECOVER_MS * `CLK_FREQ_HZ) / 1000)
`define UL_RECOVER_MS 5
`define UL_RECOVER_CYC ((`UL_RECOVER_MS * `CLK_FREQ_HZ) / 1000)
`define UL_MAX_TRIES 4'ha
`define CRC16_POLY 16'h1021
`define CRC16_INIT 16'hffff
`define ST_UL_LO 0
`define ST_UL_HI 1
`define ST_READY 2
`define ST_CMD_READY 3
`define ST_SUPPLY 4
`define ST_CABLE 5
`define ST_LAMP 6
`define ST_MOVING 7
`define ST_AX7_MOVE 8
`define ST_AX7_REF 9
`define ST_AX7_PLIM 10
`define ST_AX7_NLIM 11
`define ST_AX8_MOVE 12
`define ST_AX8_REF 13
`define ST_AX8_PLIM 14
`define ST_AX8_NLIM 15
`define LIMIT_MASK 16'hcc00
`define UL_CTRL_MASK 16'h0003
`define CB_SERVO_N 0
`define CB_PIEZO_N 1
`define CB_COMP_N 2
`define CB_EXT_N 3
`define CB_WIDTH 4
`endif

/* design/word_buffer2.v */
// Two-entry valid/ready word buffer
`timescale 1ns/100ps
`default_nettype none
module word_buffer2
#(
   parameter WIDTH = 48
)
(
   input wire clk_in,
   input wire rst_in,
   input wire [WIDTH-1:0] wr_data_in,
   input wire wr_valid_in,
   output wire wr_ready_out,
   output reg [WIDTH-1:0] rd_data_out,
   output wire rd_valid_out,
   input wire rd_ready_in
);
   reg [WIDTH-1:0] mem_reg [0:1];
   reg wr_ptr_reg;
   reg rd_ptr_reg;
   reg [1:0] count_reg;
   wire do_wr;
   wire do_rd;
   assign wr_ready_out = (count_reg != 2'h2);
   assign rd_valid_out = (count_reg != 2'h0);
   assign do_wr = wr_valid_in & wr_ready_out;
   assign do_rd = rd_valid_out & rd_ready_in;
   always @*
   begin
      rd_data_out = mem_reg[rd_ptr_reg];
   end
   always @(posedge clk_in)
   begin
      if (do_wr)
      begin
         mem_reg[wr_ptr_reg] <= wr_data_in;
      end
      if (rst_in)
      begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (do_rd)
         begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, do_wr} - {1'b0, do_rd};
      end
   end
endmodule // word_buffer2
`default_nettype wire

/* design/mirror_link_port.v */
// Mirror controller side of the link: downlink words, uplink checks, parallel ports
// Notes on behaviour
// - Status bits 0..1 uplink control, bit 2 ready, bit 3 command ready.
// - Bit 4 supply fault, bit 5 cable error, bit 6 lamp fault.
// - Bit 7 platform moving; bits 8..11 axis seven move, reference, limits.
// - Bits 12..15 axis eight move, reference, positive and negative limit.
// - Limit bits 10, 11, 14, 15 cleared on each accepted motion command.
// - Downlink handshake loss mid-frame or timeout resets link after 10 ms, then restarts.
// - During downlink recovery servo is held and drive outputs kept.
// - Uplink packets checked by CRC16; failed packets retried at most 9 times (10 tries).
// - Missing uplink handshake resets uplink after 5 ms, then resumes.
// - Uplink error handling never disturbs the periodic downlink.
// - Servo off: parallel targets go straight to converters, no slew limit.
// - Positions are 16-bit two's complement, LSB 0.002 arcsec.
// - Position inputs latch on strobe rising edge; jumper ties both strobes.
// - Control inputs latch on strobe rising edge, acting like serial commands.
// - Latched control bits are echoed on the control output.
// - Control bits active low; external-control low selects analog inputs.
// - Downlink positions output with high strobes, 15 us between axes.
// - Position outputs refresh every 100 us regardless of system state.
// - Auxiliary output carries motion controller status minus uplink bits.
// - Status output carries mirror status and pulses at waveform start.
// - Serial link runs asynchronously at 10 Mbit/s on RS-422.
`timescale 1ns/100ps
`default_nettype none
`include "mirror_link_map.vh"
module mirror_link_port
#(
   parameter POS_W = 16,
   parameter DL_RECOVER_CYC = `DL_RECOVER_CYC,
   parameter UL_RECOVER_CYC = `UL_RECOVER_CYC,
   parameter DL_TIMEOUT_CYC = 2 * `DL_PERIOD_CYC
)
(
   input wire MCLK_IN,
   input wire RST_IN,
   input wire [15:0] DL_WORD_IN,
   input wire DL_WORD_VALID_IN,
   input wire DL_HANDSHAKE_IN,
   input wire [15:0] UL_WORD_IN,
   input wire UL_WORD_VALID_IN,
   input wire UL_PKT_END_IN,
   input wire UL_HANDSHAKE_IN,
   input wire MOTION_CMD_IN,
   input wire [POS_W-1:0] POS_U_IN,
   input wire [POS_W-1:0] POS_V_IN,
   input wire POS_U_STB_IN,
   input wire POS_V_STB_IN,
   input wire POS_STROBE_TIE_JUMPER_IN,
   input wire ALL_STROBE_TIE_JUMPER_IN,
   input wire [`CB_WIDTH-1:0] CONTROL_BITS_INPUT_IN,
   input wire CTRL_STB_IN,
   input wire [3:0] MIRROR_STATUS_IN,
   input wire WAVEFORM_START_IN,
   output reg [POS_W-1:0] POS_U_BACKUP_OUT,
   output reg [POS_W-1:0] POS_V_BACKUP_OUT,
   output reg POS_U_STB_OUT,
   output reg POS_V_STB_OUT,
   output reg [15:0] STATUS_BACKUP_OUT,
   output reg [`CB_WIDTH-1:0] CTRL_ECHO_OUT,
   output reg [3:0] CTRL_STATUS_OUT,
   output reg WAVEFORM_START_PULSE_OUT,
   output reg [POS_W-1:0] DAC_U_OUT,
   output reg [POS_W-1:0] DAC_V_OUT,
   output reg SERVO_ON_OUT,
   output reg PIEZO_ON_OUT,
   output reg COMP_ON_OUT,
   output reg EXTERNAL_DRIVE_SELECT_N_OUT,
   output reg DL_RECOVERING_OUT,
   output reg UL_ACK_OUT,
   output reg UL_NAK_OUT,
   output reg UL_RESET_OUT
);
   localparam DL_IDLE = 2'h0;
   localparam DL_GOT_U = 2'h1;
   localparam DL_GOT_V = 2'h2;
   localparam DL_RECOVER = 2'h3;
   localparam UL_RUN = 1'b0;
   localparam UL_RESETTING = 1'b1;

   // CRC16 over one 16-bit word, MSB first
   function [15:0] crc16_word;
      input [15:0] crc;
      input [15:0] data;
      integer i;
      reg [15:0] c;
      begin
         c = crc;
         for (i = 15; i >= 0; i = i - 1)
         begin
            if (c[15] ^ data[i])
            begin
               c = {c[14:0], 1'b0} ^ `CRC16_POLY;
            end
            else
            begin
               c = {c[14:0], 1'b0};
            end
         end
         crc16_word = c;
      end
   endfunction

   // Downlink framing: U, V, status, then buffered for the output side
   reg [1:0] dl_state_reg;
   reg [POS_W-1:0] dl_u_reg;
   reg [POS_W-1:0] dl_v_reg;
   reg [23:0] dl_timer_reg;
   reg dl_hs_prev_reg;
   reg [47:0] dl_frame_reg;
   reg dl_frame_valid_reg;
   wire dl_buf_ready;
   wire [47:0] out_frame;
   wire out_valid;
   reg out_take;

   word_buffer2 #(.WIDTH(48)) frame_buf
   (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .wr_data_in(dl_frame_reg),
      .wr_valid_in(dl_frame_valid_reg),
      .wr_ready_out(dl_buf_ready),
      .rd_data_out(out_frame),
      .rd_valid_out(out_valid),
      .rd_ready_in(out_take)
   );

   // Handshake falling mid-frame or long silence both count as a lost link
   wire dl_hs_lost = dl_hs_prev_reg & ~DL_HANDSHAKE_IN & (dl_state_reg != DL_IDLE);
   wire dl_timeout = (dl_state_reg != DL_RECOVER) && (dl_timer_reg >= DL_TIMEOUT_CYC - 1);

   always @(posedge MCLK_IN)
   begin
      if (RST_IN)
      begin
         dl_state_reg <= DL_IDLE;
         dl_u_reg <= 16'h0000;
         dl_v_reg <= 16'h0000;
         dl_timer_reg <= 24'h000000;
         dl_hs_prev_reg <= 1'b0;
         dl_frame_reg <= 48'h000000000000;
         dl_frame_valid_reg <= 1'b0;
         DL_RECOVERING_OUT <= 1'b0;
      end
      else
      begin
         dl_hs_prev_reg <= DL_HANDSHAKE_IN;
         if (dl_buf_ready)
         begin
            dl_frame_valid_reg <= 1'b0;
         end
         if ((dl_hs_lost | dl_timeout) && dl_state_reg != DL_RECOVER)
         begin
            dl_state_reg <= DL_RECOVER;
            dl_timer_reg <= 24'h000000;
            DL_RECOVERING_OUT <= 1'b1;
         end
         else
         begin
            case (dl_state_reg)
               DL_IDLE:
               begin
                  dl_timer_reg <= dl_timer_reg + 24'h000001;
                  if (DL_WORD_VALID_IN)
                  begin
                     dl_u_reg <= DL_WORD_IN;
                     dl_state_reg <= DL_GOT_U;
                  end
               end
               DL_GOT_U:
               begin
                  dl_timer_reg <= dl_timer_reg + 24'h000001;
                  if (DL_WORD_VALID_IN)
                  begin
                     dl_v_reg <= DL_WORD_IN;
                     dl_state_reg <= DL_GOT_V;
                  end
               end
               DL_GOT_V:
               begin
                  dl_timer_reg <= dl_timer_reg + 24'h000001;
                  if (DL_WORD_VALID_IN)
                  begin
                     // No validity check on downlink data; a full buffer holds the frame until a slot frees, and the next frame overwrites it
                     dl_frame_reg <= {DL_WORD_IN, dl_v_reg, dl_u_reg};
                     dl_frame_valid_reg <= 1'b1;
                     dl_state_reg <= DL_IDLE;
                     dl_timer_reg <= 24'h000000;
                  end
               end
               DL_RECOVER:
               begin
                  dl_timer_reg <= dl_timer_reg + 24'h000001;
                  if (dl_timer_reg >= DL_RECOVER_CYC - 1)
                  begin
                     dl_state_reg <= DL_IDLE;
                     dl_timer_reg <= 24'h000000;
                     DL_RECOVERING_OUT <= 1'b0;
                  end
               end
               default:
               begin
                  dl_state_reg <= DL_IDLE;
               end
            endcase
         end
      end
   end

   // Output side: fixed 100 us cadence, U strobe then V strobe 15 us later
   reg [15:0] tick_reg;
   reg [POS_W-1:0] v_hold_reg;
   reg [15:0] status_latch_reg;
   always @*
   begin
      out_take = out_valid && (tick_reg == 16'h0000);
   end

   always @(posedge MCLK_IN)
   begin
      if (RST_IN)
      begin
         tick_reg <= 16'h0000;
         v_hold_reg <= 16'h0000;
         status_latch_reg <= 16'h0000;
         POS_U_BACKUP_OUT <= 16'h0000;
         POS_V_BACKUP_OUT <= 16'h0000;
         POS_U_STB_OUT <= 1'b0;
         POS_V_STB_OUT <= 1'b0;
         STATUS_BACKUP_OUT <= 16'h0000;
      end
      else
      begin
         // Cadence runs even with no fresh frame, repeating the last values
         if (tick_reg >= `DL_PERIOD_CYC - 1)
         begin
            tick_reg <= 16'h0000;
         end
         else
         begin
            tick_reg <= tick_reg + 16'h0001;
         end
         POS_U_STB_OUT <= (tick_reg == 16'h0000);
         POS_V_STB_OUT <= (tick_reg == `UV_GAP_CYC);
         if (out_take)
         begin
            POS_U_BACKUP_OUT <= out_frame[15:0];
            v_hold_reg <= out_frame[31:16];
            status_latch_reg <= out_frame[47:32];
         end
         if (tick_reg == `UV_GAP_CYC - 1)
         begin
            POS_V_BACKUP_OUT <= v_hold_reg;
         end
         // Limit flags drop as soon as a motion command is accepted
         if (MOTION_CMD_IN)
         begin
            status_latch_reg <= (out_take ? out_frame[47:32] : status_latch_reg)
               & ~`LIMIT_MASK;
         end
         // Fields pass through at their own positions, uplink bits forced low
         STATUS_BACKUP_OUT <= (MOTION_CMD_IN ? status_latch_reg & ~`LIMIT_MASK
            : status_latch_reg) & ~`UL_CTRL_MASK;
      end
   end

   // Uplink: CRC over each packet, ack/nak with a retry limit, reset on lost handshake
   reg ul_state_reg;
   reg [15:0] ul_crc_reg;
   reg [3:0] ul_tries_reg;
   reg [23:0] ul_timer_reg;
   reg ul_hs_prev_reg;
   wire [15:0] ul_crc_now = crc16_word(ul_crc_reg, UL_WORD_IN);

   always @(posedge MCLK_IN)
   begin
      if (RST_IN)
      begin
         ul_state_reg <= UL_RUN;
         ul_crc_reg <= `CRC16_INIT;
         ul_tries_reg <= 4'h0;
         ul_timer_reg <= 24'h000000;
         ul_hs_prev_reg <= 1'b0;
         UL_ACK_OUT <= 1'b0;
         UL_NAK_OUT <= 1'b0;
         UL_RESET_OUT <= 1'b0;
      end
      else
      begin
         ul_hs_prev_reg <= UL_HANDSHAKE_IN;
         UL_ACK_OUT <= 1'b0;
         UL_NAK_OUT <= 1'b0;
         case (ul_state_reg)
            UL_RUN:
            begin
               // Uplink logic shares nothing with the downlink path
               if (ul_hs_prev_reg & ~UL_HANDSHAKE_IN)
               begin
                  ul_state_reg <= UL_RESETTING;
                  ul_timer_reg <= 24'h000000;
                  UL_RESET_OUT <= 1'b1;
               end
               else if (UL_WORD_VALID_IN & UL_PKT_END_IN)
               begin
                  ul_crc_reg <= `CRC16_INIT;
                  if (ul_crc_now == 16'h0000)
                  begin
                     UL_ACK_OUT <= 1'b1;
                     ul_tries_reg <= 4'h0;
                  end
                  else if (ul_tries_reg + 4'h1 >= `UL_MAX_TRIES)
                  begin
                     // Give up; sender raises the error
                     UL_NAK_OUT <= 1'b1;
                     ul_tries_reg <= 4'h0;
                  end
                  else
                  begin
                     UL_NAK_OUT <= 1'b1;
                     ul_tries_reg <= ul_tries_reg + 4'h1;
                  end
               end
               else if (UL_WORD_VALID_IN)
               begin
                  ul_crc_reg <= ul_crc_now;
               end
            end
            UL_RESETTING:
            begin
               ul_timer_reg <= ul_timer_reg + 24'h000001;
               ul_crc_reg <= `CRC16_INIT;
               ul_tries_reg <= 4'h0;
               if (ul_timer_reg >= UL_RECOVER_CYC - 1)
               begin
                  ul_state_reg <= UL_RUN;
                  UL_RESET_OUT <= 1'b0;
               end
            end
            default:
            begin
               ul_state_reg <= UL_RUN;
            end
         endcase
      end
   end

   // Parallel inputs: rising-edge latches with optional strobe ties
   reg u_stb_prev_reg;
   reg v_stb_prev_reg;
   reg c_stb_prev_reg;
   reg [POS_W-1:0] tgt_u_reg;
   reg [POS_W-1:0] tgt_v_reg;
   wire all_tie = ALL_STROBE_TIE_JUMPER_IN;
   wire pos_tie = POS_STROBE_TIE_JUMPER_IN | all_tie;
   wire u_rise = POS_U_STB_IN & ~u_stb_prev_reg;
   wire v_rise_own = POS_V_STB_IN & ~v_stb_prev_reg;
   wire c_rise_own = CTRL_STB_IN & ~c_stb_prev_reg;
   wire v_rise = pos_tie ? u_rise : v_rise_own;
   wire c_rise = all_tie ? u_rise : c_rise_own;

   always @(posedge MCLK_IN)
   begin
      if (RST_IN)
      begin
         u_stb_prev_reg <= 1'b0;
         v_stb_prev_reg <= 1'b0;
         c_stb_prev_reg <= 1'b0;
         tgt_u_reg <= 16'h0000;
         tgt_v_reg <= 16'h0000;
         CTRL_ECHO_OUT <= 4'hf;
         SERVO_ON_OUT <= 1'b0;
         PIEZO_ON_OUT <= 1'b0;
         COMP_ON_OUT <= 1'b0;
         EXTERNAL_DRIVE_SELECT_N_OUT <= 1'b1;
         DAC_U_OUT <= 16'h0000;
         DAC_V_OUT <= 16'h0000;
         CTRL_STATUS_OUT <= 4'h0;
         WAVEFORM_START_PULSE_OUT <= 1'b0;
      end
      else
      begin
         u_stb_prev_reg <= POS_U_STB_IN;
         v_stb_prev_reg <= POS_V_STB_IN;
         c_stb_prev_reg <= CTRL_STB_IN;
         if (u_rise)
         begin
            tgt_u_reg <= POS_U_IN;
         end
         if (v_rise)
         begin
            tgt_v_reg <= POS_V_IN;
         end
         if (c_rise)
         begin
            CTRL_ECHO_OUT <= CONTROL_BITS_INPUT_IN;
            SERVO_ON_OUT <= ~CONTROL_BITS_INPUT_IN[`CB_SERVO_N];
            PIEZO_ON_OUT <= ~CONTROL_BITS_INPUT_IN[`CB_PIEZO_N];
            COMP_ON_OUT <= ~CONTROL_BITS_INPUT_IN[`CB_COMP_N];
            EXTERNAL_DRIVE_SELECT_N_OUT <= CONTROL_BITS_INPUT_IN[`CB_EXT_N];
         end
         // Converters frozen during downlink recovery; no slew limiting here
         if (!DL_RECOVERING_OUT && !SERVO_ON_OUT)
         begin
            DAC_U_OUT <= tgt_u_reg;
            DAC_V_OUT <= tgt_v_reg;
         end
         CTRL_STATUS_OUT <= MIRROR_STATUS_IN;
         WAVEFORM_START_PULSE_OUT <= WAVEFORM_START_IN;
      end
   end
endmodule // mirror_link_port
`default_nettype wire

/* test/mirror_link_port_monitor.sv */
// Checker for the mirror link parallel port outputs
`timescale 1ns/100ps
`default_nettype none
module mirror_link_port_monitor
#(
   parameter UL_RECOVER_CYC = 20
)
(
   input wire MCLK_IN,
   input wire RST_IN,
   input wire UL_HANDSHAKE_IN,
   input wire MOTION_CMD_IN,
   input wire WAVEFORM_START_IN,
   input wire POS_U_STB_OUT,
   input wire POS_V_STB_OUT,
   input wire [15:0] STATUS_BACKUP_OUT,
   input wire [3:0] CTRL_ECHO_OUT,
   input wire WAVEFORM_START_PULSE_OUT,
   input wire [15:0] DAC_U_OUT,
   input wire [15:0] DAC_V_OUT,
   input wire SERVO_ON_OUT,
   input wire PIEZO_ON_OUT,
   input wire COMP_ON_OUT,
   input wire EXTERNAL_DRIVE_SELECT_N_OUT,
   input wire DL_RECOVERING_OUT,
   input wire UL_ACK_OUT,
   input wire UL_NAK_OUT,
   input wire UL_RESET_OUT
);
   default clocking mon_cb @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);
   logic [9:0] ph_reg;
   logic seen_reg;
   logic [15:0] ul_cnt_reg;
   // Recovery restarts phase tracking
   always @(posedge MCLK_IN)
   begin
      if (RST_IN || DL_RECOVERING_OUT)
      begin
         seen_reg <= 1'b0;
         ph_reg <= 10'h000;
      end
      else if (POS_U_STB_OUT)
      begin
         seen_reg <= 1'b1;
         ph_reg <= 10'h001;
      end
      else
         ph_reg <= (ph_reg == 10'h3e7) ? 10'h000 : ph_reg + 10'h001;
      ul_cnt_reg <= UL_RESET_OUT ? ul_cnt_reg + 16'h0001 : 16'h0000;
   end
   a_aux_low_zero: assert property (STATUS_BACKUP_OUT[1:0] == 2'b00)
      else $error("uplink bits not zero");
   a_v_after_u: assert property (POS_U_STB_OUT |-> ##150 POS_V_STB_OUT)
      else $error("V strobe late");
   a_u_cadence: assert property (POS_U_STB_OUT && seen_reg |-> ph_reg == 10'h000)
      else $error("U strobe off cadence");
   a_limit_clear: assert property (MOTION_CMD_IN |=> POS_U_STB_OUT ||
      ((STATUS_BACKUP_OUT & 16'hcc00) == 16'h0000))
      else $error("limits kept");
   a_on_levels: assert property ({COMP_ON_OUT, PIEZO_ON_OUT, SERVO_ON_OUT} ==
      ~CTRL_ECHO_OUT[2:0])
      else $error("on levels differ from echo");
   a_ext_select: assert property (EXTERNAL_DRIVE_SELECT_N_OUT == CTRL_ECHO_OUT[3])
      else $error("external select wrong");
   a_wave_pulse: assert property (WAVEFORM_START_IN |=> WAVEFORM_START_PULSE_OUT)
      else $error("waveform marker missing");
   a_dac_hold_rec: assert property (DL_RECOVERING_OUT && $past(DL_RECOVERING_OUT) |->
      $stable(DAC_U_OUT) && $stable(DAC_V_OUT))
      else $error("drive changed in recovery");
   a_dac_hold_servo: assert property (SERVO_ON_OUT && $past(SERVO_ON_OUT) |->
      $stable(DAC_U_OUT) && $stable(DAC_V_OUT))
      else $error("drive bypassed servo");
   a_ack_nak_excl: assert property (!(UL_ACK_OUT && UL_NAK_OUT))
      else $error("ack and nak together");
   a_ul_reset_rise: assert property ($fell(UL_HANDSHAKE_IN) |-> ##[1:2] UL_RESET_OUT)
      else $error("uplink reset not raised");
   a_ul_reset_len: assert property (UL_RESET_OUT |-> ul_cnt_reg < UL_RECOVER_CYC)
      else $error("uplink reset too long");
   a_ul_quiet: assert property (UL_RESET_OUT |-> !UL_ACK_OUT)
      else $error("ack during uplink reset");
endmodule // mirror_link_port_monitor
bind mirror_link_port mirror_link_port_monitor #(.UL_RECOVER_CYC(UL_RECOVER_CYC)) u_mon
   (.MCLK_IN, .RST_IN, .UL_HANDSHAKE_IN, .MOTION_CMD_IN, .WAVEFORM_START_IN, .POS_U_STB_OUT,
   .POS_V_STB_OUT, .STATUS_BACKUP_OUT, .CTRL_ECHO_OUT, .WAVEFORM_START_PULSE_OUT, .DAC_U_OUT,
   .DAC_V_OUT, .SERVO_ON_OUT, .PIEZO_ON_OUT, .COMP_ON_OUT, .EXTERNAL_DRIVE_SELECT_N_OUT,
   .DL_RECOVERING_OUT, .UL_ACK_OUT, .UL_NAK_OUT, .UL_RESET_OUT);
`default_nettype wire

/* test/motion_ctrl_model.sv */
// Motion controller downlink model: one frame every 1000 cycles
`timescale 1ns/100ps
`default_nettype none
module motion_ctrl_model
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic en_in,
   input wire logic [15:0] u_in,
   input wire logic [15:0] v_in,
   input wire logic [15:0] st_in,
   output logic [15:0] word_out,
   output logic valid_out
);
   logic [9:0] tick_reg;
   always @(posedge clk_in)
   begin
      if (rst_in || tick_reg == 10'h3e7)
         tick_reg <= 10'h000;
      else
         tick_reg <= tick_reg + 10'h001;
      valid_out <= en_in && !rst_in && tick_reg < 10'h003;
      case (tick_reg)
         10'h000: word_out <= u_in;
         10'h001: word_out <= v_in;
         10'h002: word_out <= st_in;
         // Bus left toggling between frames so stale data cannot pass
         default: word_out <= ~word_out;
      endcase
   end
endmodule // motion_ctrl_model
`default_nettype wire

/* test/mirror_link_port_tb_top.sv */
// Self-checking testbench of the mirror link parallel port
`timescale 1ns/100ps
`default_nettype none
`include "mirror_link_map.vh"
module mirror_link_port_tb_top;
   localparam int UL_RC = 20;
   localparam int DL_RC = 50;
   logic MCLK_IN = 1'b0, RST_IN = 1'b1, UL_HANDSHAKE_IN = 1'b1, DL_HANDSHAKE_IN = 1'b1;
   logic UL_WORD_VALID_IN = 1'b0, UL_PKT_END_IN = 1'b0, MOTION_CMD_IN = 1'b0;
   logic POS_U_STB_IN = 1'b0, POS_V_STB_IN = 1'b0, CTRL_STB_IN = 1'b0, WAVEFORM_START_IN = 1'b0;
   logic POS_STROBE_TIE_JUMPER_IN = 1'b0, ALL_STROBE_TIE_JUMPER_IN = 1'b0, dl_en = 1'b1;
   logic [15:0] UL_WORD_IN = 16'h0000, POS_U_IN = 16'h0000, POS_V_IN = 16'h0000;
   logic [15:0] mu = 16'h0000, mv = 16'h0000, mst = 16'h0000;
   logic [3:0] CONTROL_BITS_INPUT_IN = 4'hf, MIRROR_STATUS_IN = 4'h0;
   wire [15:0] DL_WORD_IN, POS_U_BACKUP_OUT, POS_V_BACKUP_OUT, STATUS_BACKUP_OUT;
   wire [15:0] DAC_U_OUT, DAC_V_OUT;
   wire [3:0] CTRL_ECHO_OUT, CTRL_STATUS_OUT;
   wire DL_WORD_VALID_IN, POS_U_STB_OUT, POS_V_STB_OUT, WAVEFORM_START_PULSE_OUT, SERVO_ON_OUT;
   wire PIEZO_ON_OUT, COMP_ON_OUT, EXTERNAL_DRIVE_SELECT_N_OUT, DL_RECOVERING_OUT;
   wire UL_ACK_OUT, UL_NAK_OUT, UL_RESET_OUT;
   int n_fail = 0;
   int compares = 0;
   mirror_link_port #(.DL_RECOVER_CYC(DL_RC), .UL_RECOVER_CYC(UL_RC), .DL_TIMEOUT_CYC(3000)) dut
      (.MCLK_IN, .RST_IN, .DL_WORD_IN, .DL_WORD_VALID_IN, .DL_HANDSHAKE_IN, .UL_WORD_IN,
      .UL_WORD_VALID_IN, .UL_PKT_END_IN, .UL_HANDSHAKE_IN, .MOTION_CMD_IN, .POS_U_IN, .POS_V_IN,
      .POS_U_STB_IN, .POS_V_STB_IN, .POS_STROBE_TIE_JUMPER_IN, .ALL_STROBE_TIE_JUMPER_IN,
      .CONTROL_BITS_INPUT_IN, .CTRL_STB_IN, .MIRROR_STATUS_IN, .WAVEFORM_START_IN,
      .POS_U_BACKUP_OUT, .POS_V_BACKUP_OUT, .POS_U_STB_OUT, .POS_V_STB_OUT, .STATUS_BACKUP_OUT,
      .CTRL_ECHO_OUT, .CTRL_STATUS_OUT, .WAVEFORM_START_PULSE_OUT, .DAC_U_OUT, .DAC_V_OUT,
      .SERVO_ON_OUT, .PIEZO_ON_OUT, .COMP_ON_OUT, .EXTERNAL_DRIVE_SELECT_N_OUT,
      .DL_RECOVERING_OUT, .UL_ACK_OUT, .UL_NAK_OUT, .UL_RESET_OUT);
   motion_ctrl_model partner (.clk_in(MCLK_IN), .rst_in(RST_IN), .en_in(dl_en), .u_in(mu),
      .v_in(mv), .st_in(mst), .word_out(DL_WORD_IN), .valid_out(DL_WORD_VALID_IN));
   initial
   begin
      forever #50 MCLK_IN = ~MCLK_IN;
   end
   task automatic final_report;
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   // Sample one step past the edge so its updates have landed
   task automatic tick;
      @(posedge MCLK_IN);
      #1;
   endtask
   task automatic wait_u;
      for (int i = 0; i < 2100 && POS_U_STB_OUT !== 1'b1; i++) tick;
      chk(POS_U_STB_OUT === 1'b1, "no U strobe");
   endtask
   function automatic logic [15:0] crc_w(input logic [15:0] c, input logic [15:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--) r = {r[14:0], 1'b0} ^
         ((r[15] ^ d[i]) ? `CRC16_POLY : 16'h0000);
      return r;
   endfunction
   task automatic send_pkt(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] x,
      output logic [1:0] res);
      @(posedge MCLK_IN);
      UL_WORD_IN <= w0;
      UL_WORD_VALID_IN <= 1'b1;
      @(posedge MCLK_IN);
      UL_WORD_IN <= w1;
      @(posedge MCLK_IN);
      UL_WORD_IN <= crc_w(crc_w(`CRC16_INIT, w0), w1) ^ x;
      UL_PKT_END_IN <= 1'b1;
      @(posedge MCLK_IN);
      UL_WORD_VALID_IN <= 1'b0;
      UL_PKT_END_IN <= 1'b0;
      #1 res = {UL_ACK_OUT, UL_NAK_OUT};
      repeat (4)
      begin
         tick;
         res = res | {UL_ACK_OUT, UL_NAK_OUT};
      end
   endtask
   task automatic t_frame;
      int i;
      @(posedge MCLK_IN);
      mu <= 16'h8001;
      mv <= 16'h7ffe;
      mst <= 16'hcfff;
      wait_u;
      tick;
      wait_u;
      chk(POS_U_BACKUP_OUT === 16'h8001, "U position");
      chk(STATUS_BACKUP_OUT === 16'hcffc, "status word");
      for (i = 0; i < 200 && POS_V_STB_OUT !== 1'b1; i++) tick;
      chk(i == 150, "V strobe delay");
      chk(POS_V_BACKUP_OUT === 16'h7ffe, "V position");
      @(posedge MCLK_IN);
      MOTION_CMD_IN <= 1'b1;
      @(posedge MCLK_IN);
      MOTION_CMD_IN <= 1'b0;
      tick;
      chk(STATUS_BACKUP_OUT === 16'h03fc, "limits not cleared");
   endtask
   task automatic t_ctrl;
      logic [3:0] tbl [4] = '{4'he, 4'h7, 4'h0, 4'hf};
      for (int k = 0; k < 4; k++)
      begin
         @(posedge MCLK_IN);
         CONTROL_BITS_INPUT_IN <= tbl[k];
         @(posedge MCLK_IN);
         CTRL_STB_IN <= 1'b1;
         repeat (3) tick;
         chk(CTRL_ECHO_OUT === tbl[k], "echo");
         chk({EXTERNAL_DRIVE_SELECT_N_OUT, COMP_ON_OUT, PIEZO_ON_OUT, SERVO_ON_OUT} ===
            {tbl[k][3], ~tbl[k][2:0]}, "control levels");
         @(posedge MCLK_IN);
         CTRL_STB_IN <= 1'b0;
      end
   endtask
   task automatic t_pos;
      @(posedge MCLK_IN);
      POS_STROBE_TIE_JUMPER_IN <= 1'b1;
      POS_U_IN <= 16'h8000;
      POS_V_IN <= 16'h7fff;
      @(posedge MCLK_IN);
      POS_U_STB_IN <= 1'b1;
      repeat (4) tick;
      chk(DAC_U_OUT === 16'h8000 && DAC_V_OUT === 16'h7fff, "tied latch");
      @(posedge MCLK_IN);
      POS_U_STB_IN <= 1'b0;
      POS_STROBE_TIE_JUMPER_IN <= 1'b0;
      POS_U_IN <= 16'h4321;
      POS_V_IN <= 16'h1234;
      @(posedge MCLK_IN);
      POS_V_STB_IN <= 1'b1;
      repeat (4) tick;
      chk(DAC_U_OUT === 16'h8000 && DAC_V_OUT === 16'h1234, "V strobe alone");
      @(posedge MCLK_IN);
      POS_V_STB_IN <= 1'b0;
      ALL_STROBE_TIE_JUMPER_IN <= 1'b1;
      CONTROL_BITS_INPUT_IN <= 4'he;
      @(posedge MCLK_IN);
      POS_U_STB_IN <= 1'b1;
      repeat (4) tick;
      chk(CTRL_ECHO_OUT === 4'he, "control on U strobe");
      @(posedge MCLK_IN);
      POS_U_STB_IN <= 1'b0;
   endtask
   task automatic t_uplink;
      logic [1:0] res;
      int n;
      send_pkt(16'h1234, 16'habcd, 16'h0000, res);
      chk(res === 2'b10, "good packet not acked");
      send_pkt(16'h1234, 16'habcd, 16'h0001, res);
      chk(res === 2'b01, "bad packet not refused");
      @(posedge MCLK_IN);
      UL_HANDSHAKE_IN <= 1'b0;
      for (n = 0; n < 4 && UL_RESET_OUT !== 1'b1; n++) tick;
      UL_HANDSHAKE_IN <= 1'b1;
      for (n = 0; n < 100 && UL_RESET_OUT === 1'b1; n++) tick;
      chk(n == UL_RC, "uplink reset length");
      send_pkt(16'h0055, 16'h00aa, 16'h0000, res);
      chk(res === 2'b10 && DL_RECOVERING_OUT === 1'b0, "uplink resume");
      wait_u;
   endtask
   task automatic t_downlink;
      int n;
      @(posedge MCLK_IN);
      dl_en <= 1'b0;
      for (n = 0; n < 4200 && DL_RECOVERING_OUT !== 1'b1; n++) tick;
      chk(DL_RECOVERING_OUT === 1'b1, "no recovery on timeout");
      for (n = 0; n < 200 && DL_RECOVERING_OUT === 1'b1; n++) tick;
      chk(n == DL_RC, "recovery length");
      dl_en <= 1'b1;
      wait_u;
      @(posedge MCLK_IN);
      DL_HANDSHAKE_IN <= 1'b0;
      tick;
      chk(DL_RECOVERING_OUT === 1'b1, "no hs recovery");
   endtask
   task automatic t_wave;
      @(posedge MCLK_IN);
      WAVEFORM_START_IN <= 1'b1;
      MIRROR_STATUS_IN <= 4'ha;
      @(posedge MCLK_IN);
      WAVEFORM_START_IN <= 1'b0;
      #1;
      chk(WAVEFORM_START_PULSE_OUT === 1'b1, "waveform marker");
      tick;
      chk(CTRL_STATUS_OUT === 4'ha, "mirror status");
   endtask
   initial
   begin
      repeat (5) @(posedge MCLK_IN);
      RST_IN <= 1'b0;
      t_frame;
      t_ctrl;
      t_pos;
      t_uplink;
      t_wave;
      t_downlink;
      final_report;
   end
   initial
   begin
      repeat (20000) @(posedge MCLK_IN);
      n_fail++;
      final_report;
   end
endmodule // mirror_link_port_tb_top
`default_nettype wire
